// ===== verilog/cpmd_charge_port_mode_decoder.v
// Charging port mode decoder with CDP/SDP fallback and thermal restart
// What this block does
// - Pattern 100x stays forced in shorted charging, never auto switching.
// - Pattern 101x stays forced in divider charging; fourth pin picks limit.
// - Outside the fallback SDP phase, changing between 1111 and 1110 never discharges the output.
// - Pattern 1110 is second standard data port, low limit, data on.
// - Pattern 0110 is automatic dedicated charging at high limit.
// - Pattern 010x is first standard data port; fourth pin picks limit.
// - In CDP, detect phone classed port as charger without data link.
// - On detection, discharge output, then present the port as SDP.
// - After phone connects as SDP, return to CDP without discharge.
// - Two independent limit thresholds; decoded pattern selects one, none for pattern 000x.
// - Thermal shutdown keeps switch off until cooled, then restarts.
// - Low threshold unused whenever limit choice pin is held high.
// - Reset holds initial discharge state, then follows the pins.
// - Data switches off on enable low, discharge or dedicated modes.
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
`include "cpmd_consts.vh"

module cpmd_charge_port_mode_decoder (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        mode_select_pin_a_i,
	input  wire        mode_select_pin_b_i,
	input  wire        mode_select_pin_c_i,
	input  wire        limit_choice_pin_i,
	input  wire        enable_i,
	input  wire        over_temp_i,
	input  wire        cooled_i,
	input  wire        phone_dcp_no_data_i,
	input  wire        phone_data_link_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output reg         power_switch_on_o,
	output reg         discharge_on_o,
	output reg         data_switch_on_o,
	output reg         upper_threshold_sel_o,
	output reg         lower_threshold_sel_o,
	output reg  [2:0]  mode_o
);

	localparam [2:0] ST_INIT  = 3'h0;
	localparam [2:0] ST_RUN   = 3'h1;
	localparam [2:0] ST_DCHG  = 3'h2;
	localparam [2:0] ST_FSDP  = 3'h3;
	localparam [2:0] ST_THERM = 3'h4;

	localparam [9:0] TICK_CYC  = `CPMD_TICK_CYC;
	localparam [6:0] TICK_LAST = TICK_CYC[6:0] - 7'd1;

	// Pin synchronisers
	reg  [5:0]  sync1_ff;
	reg  [5:0]  sync2_ff;
	reg  [2:0]  state_ff;
	reg  [2:0]  nxt_state;
	reg  [2:0]  mode_ff;
	reg  [6:0]  tick_ff;
	reg  [7:0]  tmr_ff;
	reg  [7:0]  nxt_tmr;
	reg         fback_ff;
	reg         nxt_fback;
	reg  [2:0]  ctrl_ff;
	reg  [15:0] cfg_ff;
	reg  [2:0]  oth_ff;
	reg  [1:0]  ev_ff;
	wire [2:0]  pins;
	wire        lim;
	wire        en_s;
	wire        tick;
	wire        phone_dcp;
	wire        phone_link;
	wire        ovl;
	wire        cool;
	wire        no_dchg;
	wire [2:0]  pin_mode;
	wire        bus_req;
	wire        wr_ok;

	// Decode the three mode select pins into a mode code
	function [2:0] cpmd_decode;
		input [2:0] p;
		begin
			case (p)
				3'b000:  cpmd_decode = `CPMD_M_DISCHG;
				3'b001:  cpmd_decode = `CPMD_M_AUTO_DCP;
				3'b010:  cpmd_decode = `CPMD_M_STANDARD_DATA_PORT_FIRST;
				3'b011:  cpmd_decode = `CPMD_M_AUTO_DCP;
				3'b100:  cpmd_decode = `CPMD_M_SHORTED;
				3'b101:  cpmd_decode = `CPMD_M_DIVIDER;
				3'b110:  cpmd_decode = `CPMD_M_STANDARD_DATA_PORT_FIRST;
				default: cpmd_decode = `CPMD_M_CDP;
			endcase
		end
	endfunction

	// Full pattern 111x splits on the limit choice pin
	function [2:0] cpmd_mode;
		input [2:0] p;
		input       l;
		begin
			if (p == 3'b111)
				cpmd_mode = l ? `CPMD_M_CDP : `CPMD_M_STANDARD_DATA_PORT_SECOND;
			else
				cpmd_mode = cpmd_decode(p);
		end
	endfunction

	// Modes that carry a data connection through the switch
	function cpmd_is_data;
		input [2:0] m;
		begin
			case (m)
				`CPMD_M_STANDARD_DATA_PORT_FIRST: cpmd_is_data = 1'b1;
				`CPMD_M_STANDARD_DATA_PORT_SECOND: cpmd_is_data = 1'b1;
				`CPMD_M_CDP:  cpmd_is_data = 1'b1;
				default:      cpmd_is_data = 1'b0;
			endcase
		end
	endfunction

	// Upper threshold: fixed for discharge, auto, CDP and STANDARD_DATA_PORT_SECOND, else the choice pin
	function cpmd_hi_lim;
		input [2:0] m;
		input       l;
		begin
			case (m)
				`CPMD_M_DISCHG:   cpmd_hi_lim = 1'b0;
				`CPMD_M_AUTO_DCP: cpmd_hi_lim = 1'b1;
				`CPMD_M_CDP:      cpmd_hi_lim = 1'b1;
				`CPMD_M_STANDARD_DATA_PORT_SECOND:     cpmd_hi_lim = 1'b0;
				default:          cpmd_hi_lim = l;
			endcase
		end
	endfunction

	// Lower threshold: fixed for discharge, auto, CDP and STANDARD_DATA_PORT_SECOND, else the inverse of the choice pin
	function cpmd_lo_lim;
		input [2:0] m;
		input       l;
		begin
			case (m)
				`CPMD_M_DISCHG:   cpmd_lo_lim = 1'b0;
				`CPMD_M_AUTO_DCP: cpmd_lo_lim = 1'b0;
				`CPMD_M_CDP:      cpmd_lo_lim = 1'b0;
				`CPMD_M_STANDARD_DATA_PORT_SECOND:     cpmd_lo_lim = 1'b1;
				default:          cpmd_lo_lim = !l;
			endcase
		end
	endfunction

	// States in which the supply switch may conduct
	function cpmd_live;
		input [2:0] s;
		begin
			case (s)
				ST_RUN:  cpmd_live = 1'b1;
				ST_FSDP: cpmd_live = 1'b1;
				default: cpmd_live = 1'b0;
			endcase
		end
	endfunction

	always @(posedge clk_i) begin
		if (rst_i) begin
			sync1_ff <= 6'h00;
			sync2_ff <= 6'h00;
		end else begin
			sync1_ff <= {cooled_i, over_temp_i, enable_i, limit_choice_pin_i,
				mode_select_pin_c_i, mode_select_pin_a_i};
			sync2_ff <= sync1_ff;
		end
	end

	// Pins b and phone signals also cross, kept in a second pair
	always @(posedge clk_i) begin
		if (rst_i) begin
			oth_ff <= 3'h0;
			ev_ff  <= 2'h0;
		end else begin
			oth_ff <= {phone_data_link_i, phone_dcp_no_data_i,
				mode_select_pin_b_i};
			ev_ff  <= {oth_ff[2], oth_ff[1]};
		end
	end

	reg pin_b_ff;
	always @(posedge clk_i) begin
		if (rst_i)
			pin_b_ff <= 1'b0;
		else
			pin_b_ff <= oth_ff[0];
	end

	assign pins       = {sync2_ff[0], pin_b_ff, sync2_ff[1]};
	assign lim        = sync2_ff[2];
	assign en_s       = sync2_ff[3];
	assign ovl        = sync2_ff[4] | ctrl_ff[`CPMD_CTRL_OVL];
	assign cool       = sync2_ff[5];
	assign phone_dcp  = ev_ff[0] | ctrl_ff[`CPMD_CTRL_PHONE];
	assign phone_link = ev_ff[1];
	assign pin_mode   = cpmd_mode(pins, lim);
	// Moves between CDP and STANDARD_DATA_PORT_SECOND keep the supply up
	assign no_dchg = ((mode_ff == `CPMD_M_CDP) &&
		(pin_mode == `CPMD_M_STANDARD_DATA_PORT_SECOND)) ||
		((mode_ff == `CPMD_M_STANDARD_DATA_PORT_SECOND) &&
		(pin_mode == `CPMD_M_CDP));

	// Microsecond tick
	assign tick = (tick_ff == TICK_LAST);
	always @(posedge clk_i) begin
		if (rst_i || tick)
			tick_ff <= 7'h00;
		else
			tick_ff <= tick_ff + 7'h01;
	end

	always @* begin
		nxt_state = state_ff;
		nxt_tmr   = tmr_ff;
		nxt_fback = fback_ff;
		if (tick && (tmr_ff != 8'h00))
			nxt_tmr = tmr_ff - 8'h01;
		case (state_ff)
			ST_INIT: begin
				nxt_state = ST_DCHG;
				nxt_tmr   = cfg_ff[7:0];
				nxt_fback = 1'b0;
			end
			ST_RUN: begin
				if (ovl) begin
					nxt_state = ST_THERM;
				end else if (pin_mode != mode_ff && !no_dchg) begin
					nxt_state = ST_DCHG;
					nxt_tmr   = cfg_ff[7:0];
				end else if (mode_ff == `CPMD_M_CDP && phone_dcp &&
					!phone_link && ctrl_ff[`CPMD_CTRL_FULL]) begin
					nxt_state = ST_DCHG;
					nxt_tmr   = cfg_ff[7:0];
					nxt_fback = 1'b1;
				end
			end
			ST_DCHG: begin
				// Only a fallback discharge leads on to the SDP phase
				if (pin_mode != `CPMD_M_CDP)
					nxt_fback = 1'b0;
				if (tmr_ff == 8'h00 && pin_mode != `CPMD_M_DISCHG) begin
					nxt_fback = 1'b0;
					if (fback_ff && pin_mode == `CPMD_M_CDP) begin
						nxt_state = ST_FSDP;
						nxt_tmr   = cfg_ff[15:8];
					end else begin
						nxt_state = ST_RUN;
					end
				end
			end
			ST_FSDP: begin
				if (ovl)
					nxt_state = ST_THERM;
				else if (pin_mode != `CPMD_M_CDP) begin
					nxt_state = ST_DCHG;
					nxt_tmr   = cfg_ff[7:0];
				end else if (phone_link && tmr_ff == 8'h00)
					nxt_state = ST_RUN;
			end
			ST_THERM: begin
				if (cool)
					nxt_state = ST_RUN;
			end
			default: nxt_state = ST_INIT;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= ST_INIT;
			tmr_ff   <= 8'h00;
			mode_ff  <= `CPMD_M_DISCHG;
			fback_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			tmr_ff   <= nxt_tmr;
			fback_ff <= nxt_fback;
			if (state_ff == ST_DCHG || state_ff == ST_INIT ||
				(state_ff == ST_RUN && no_dchg))
				mode_ff <= pin_mode;
		end
	end

	// Outputs
	always @(posedge clk_i) begin
		if (rst_i) begin
			power_switch_on_o     <= 1'b0;
			discharge_on_o        <= 1'b1;
			data_switch_on_o      <= 1'b0;
			upper_threshold_sel_o <= 1'b0;
			lower_threshold_sel_o <= 1'b0;
			mode_o                <= `CPMD_M_DISCHG;
		end else begin
			power_switch_on_o <= en_s && cpmd_live(state_ff);
			discharge_on_o    <= (state_ff == ST_DCHG) ||
				(state_ff == ST_INIT);
			data_switch_on_o  <= en_s && cpmd_live(state_ff) &&
				cpmd_is_data(mode_ff);
			upper_threshold_sel_o <= cpmd_hi_lim(mode_ff, lim);
			lower_threshold_sel_o <= cpmd_lo_lim(mode_ff, lim);
			mode_o <= (state_ff == ST_FSDP) ? `CPMD_M_STANDARD_DATA_PORT_FIRST : mode_ff;
		end
	end

	// Wishbone classic slave, registered ack after one wait state
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_ok   = bus_req && wb_we_i && wb_sel_i[0];

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			ctrl_ff  <= `CPMD_CTRL_RST;
			cfg_ff   <= `CPMD_CFG_RST;
		end else begin
			wb_ack_o <= bus_req;
			if (wr_ok && wb_adr_i == `CPMD_ADR_CTRL)
				ctrl_ff <= wb_dat_i[2:0];
			if (wr_ok && wb_adr_i == `CPMD_ADR_CONFIG)
				cfg_ff[7:0] <= wb_dat_i[7:0];
			if (bus_req && wb_we_i && wb_sel_i[1] &&
				wb_adr_i == `CPMD_ADR_CONFIG)
				cfg_ff[15:8] <= wb_dat_i[15:8];
			case (wb_adr_i)
				`CPMD_ADR_CTRL:   wb_dat_o <= {29'h0, ctrl_ff};
				`CPMD_ADR_STATUS: wb_dat_o <= {22'h0, pin_mode, mode_ff,
					state_ff, en_s};
				`CPMD_ADR_CONFIG: wb_dat_o <= {16'h0, cfg_ff};
				default:          wb_dat_o <= 32'h00000000;
			endcase
		end
	end

endmodule // cpmd_charge_port_mode_decoder

// ===== pkg/cpmd_consts.vh
// Constants for the charging port mode decoder
`ifndef CPMD_CONSTS_VH
`define CPMD_CONSTS_VH

// Register byte offsets
`define CPMD_ADR_CTRL      4'h0
`define CPMD_ADR_STATUS    4'h4
`define CPMD_ADR_CONFIG    4'h8

// Control register fields
`define CPMD_CTRL_FULL     2'd0
`define CPMD_CTRL_PHONE    2'd1
`define CPMD_CTRL_OVL      2'd2
`define CPMD_CTRL_RST      3'h0

// Config register: discharge time, SDP dwell time in us
`define CPMD_CFG_RST       16'h000a
`define CPMD_CFG_DWELL_LSB 5'd8

// Mode codes
`define CPMD_M_DISCHG      3'h0
`define CPMD_M_AUTO_DCP    3'h1
`define CPMD_M_SHORTED     3'h2
`define CPMD_M_DIVIDER     3'h3
`define CPMD_M_STANDARD_DATA_PORT_FIRST        3'h4
`define CPMD_M_STANDARD_DATA_PORT_SECOND        3'h5
`define CPMD_M_CDP         3'h6

// Timing: one microsecond tick at 100 MHz
`define CPMD_TICK_NS       10'd1000
`define CPMD_CLK_NS        10'd10
`define CPMD_TICK_CYC      (`CPMD_TICK_NS / `CPMD_CLK_NS)

`endif

// ===== dv/cpmd_props.sv
// Output relations checked on the mode decoder ports
`timescale 1ns/10ps
module cpmd_props (
	input wire       clk_i,
	input wire       rst_i,
	input wire       over_temp_i,
	input wire       power_switch_on_o,
	input wire       discharge_on_o,
	input wire       data_switch_on_o,
	input wire       upper_threshold_sel_o,
	input wire       lower_threshold_sel_o,
	input wire [2:0] mode_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	reset_state_a:
	assert property ($fell(rst_i) |-> discharge_on_o && mode_o == 3'h0)
		else $error("not discharging after reset");
	dchg_no_data_a:
	assert property (discharge_on_o |-> !data_switch_on_o)
		else $error("data switch on while discharging");
	dchg_no_power_a:
	assert property (discharge_on_o |-> !power_switch_on_o)
		else $error("power on while discharging");
	dcp_no_data_a:
	assert property (mode_o inside {3'h1, 3'h2, 3'h3} |-> !data_switch_on_o)
		else $error("data switch on in charger mode");
	one_limit_a:
	assert property (!(upper_threshold_sel_o && lower_threshold_sel_o))
		else $error("both limits selected");
	standard_data_port_second_low_a:
	assert property (mode_o == 3'h5 |-> lower_threshold_sel_o)
		else $error("second data port not on low limit");
	high_limit_a:
	assert property (mode_o inside {3'h1, 3'h6} |-> upper_threshold_sel_o)
		else $error("high limit missing");
	cdp_standard_data_port_second_a:
	assert property (mode_o == 3'h6 ##1 mode_o == 3'h5 |-> !discharge_on_o[*3])
		else $error("discharge on CDP to STANDARD_DATA_PORT_SECOND change");
	therm_off_a:
	assert property (over_temp_i[*8] |-> !power_switch_on_o)
		else $error("switch on during overheat");
	cover property (mode_o == 3'h6 ##1 mode_o == 3'h5);
	cover property (mode_o == 3'h4 && data_switch_on_o);
	cover property ($fell(power_switch_on_o));
endmodule // cpmd_props

bind cpmd_charge_port_mode_decoder cpmd_props u_props (.clk_i(clk_i),
	.rst_i(rst_i), .over_temp_i(over_temp_i),
	.power_switch_on_o(power_switch_on_o), .discharge_on_o(discharge_on_o),
	.data_switch_on_o(data_switch_on_o), .mode_o(mode_o),
	.upper_threshold_sel_o(upper_threshold_sel_o),
	.lower_threshold_sel_o(lower_threshold_sel_o));

// ===== dv/cpmd_phone_model.sv
// Phone that misreads a CDP port as a plain charger
`timescale 1ns/10ps
module cpmd_phone_model (
	input  wire       clk_i,
	input  wire       attach_i,
	input  wire       power_on_i,
	input  wire       data_on_i,
	input  wire [2:0] mode_i,
	output reg        dcp_no_data_o,
	output reg        link_o
);
	initial begin
		dcp_no_data_o = 1'b0;
		link_o = 1'b0;
	end
	always @(posedge clk_i) begin
		// Classes a powered CDP port as charger until it has enumerated
		dcp_no_data_o <= attach_i && power_on_i && mode_i == 3'h6 && !link_o;
		// Enumerates on the first standard data port (mode 4) and stays linked while attached
		link_o <= attach_i && (link_o || (data_on_i && mode_i == 3'h4));
	end
endmodule // cpmd_phone_model

// ===== dv/test_charge_port_mode_decoder.sv
// Self-checking bench for the charging port mode decoder
`timescale 1ns/10ps
module test_charge_port_mode_decoder;
	logic        clk_i, rst_i, cyc, stb, we, en, ot, cool, att;
	logic [3:0]  pins, adr, sel;
	logic [31:0] wdat, rd;
	wire  [31:0] rdat;
	wire         ack, pwr, dis, dsw, hi, lo, dnd, lnk;
	wire  [2:0]  mode;
	int          bad_count = 0, compares = 0, cyc_n = 0;
	cpmd_charge_port_mode_decoder uut (.clk_i(clk_i), .rst_i(rst_i),
		.mode_select_pin_a_i(pins[3]), .mode_select_pin_b_i(pins[2]),
		.mode_select_pin_c_i(pins[1]), .limit_choice_pin_i(pins[0]),
		.enable_i(en), .over_temp_i(ot), .cooled_i(cool),
		.phone_dcp_no_data_i(dnd), .phone_data_link_i(lnk), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.power_switch_on_o(pwr), .discharge_on_o(dis), .data_switch_on_o(dsw),
		.upper_threshold_sel_o(hi), .lower_threshold_sel_o(lo), .mode_o(mode));
	cpmd_phone_model phone (.clk_i(clk_i), .attach_i(att), .power_on_i(pwr),
		.data_on_i(dsw), .mode_i(mode), .dcp_no_data_o(dnd), .link_o(lnk));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 60000) begin
			bad_count++;
			end_of_test();
		end
	end
	function automatic logic [2:0] exp_mode(logic [3:0] p);
		casez (p)
			4'b000?: return 3'h0;
			4'b0?1?: return 3'h1;
			4'b100?: return 3'h2;
			4'b101?: return 3'h3;
			4'b111?: return p[0] ? 3'h6 : 3'h5;
			default: return 3'h4;
		endcase
	endfunction
	task chk(logic [31:0] got, logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wb(logic w, logic [3:0] a, logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task settle(logic [3:0] p);
		int n;
		logic [2:0] m;
		m = exp_mode(p);
		@(posedge clk_i);
		pins <= p;
		n = 0;
		while ((n < 6 || dis !== (m == 3'h0) || mode !== m) && n < 1500) begin
			@(posedge clk_i);
			n++;
		end
		repeat (2) @(posedge clk_i);
		chk(mode, m);
		chk(hi, m != 3'h0 && (p[0] || m == 3'h1));
		chk(lo, m != 3'h0 && !p[0] && m != 3'h1);
		chk(dsw, en && m >= 3'h4);
		chk(pwr, en && m != 3'h0);
	endtask
	task end_of_test();
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		int n, sd, sp, bk, late;
		{rst_i, cyc, stb, we, en, ot, cool, att} = 8'h88;
		{pins, adr, wdat} = '0;
		sel = 4'hf;
		void'($urandom(98505));
		repeat (16) @(posedge clk_i);
		chk({dis, mode}, 4'h8);
		rst_i <= 1'b0;
		wb(0, 4'h8, 0);
		chk(rd, 32'h0000000a);
		wb(1, 4'h8, 32'h1);
		wb(0, 4'h8, 0);
		chk(rd, 32'h00000001);
		sel <= 4'h0;
		wb(1, 4'h8, 32'h55);
		sel <= 4'hf;
		wb(0, 4'h8, 0);
		chk(rd, 32'h00000001);
		wb(0, 4'hc, 0);
		chk(rd, 0);
		wb(0, 4'h0, 0);
		chk(rd, 0);
		$display("register test done");
		for (int i = 0; i < 16; i++)
			settle(4'(i));
		repeat (20) begin
			en <= 1'($urandom);
			settle(4'($urandom));
		end
		en <= 1'b1;
		$display("pin table test done");
		settle(4'hf);
		for (int k = 0; k < 2; k++) begin
			pins <= k ? 4'hf : 4'he;
			n = 0;
			repeat (40) begin
				@(posedge clk_i);
				n += (dis !== 1'b0);
			end
			chk({n[7:0], mode}, {8'h0, k ? 3'h6 : 3'h5});
		end
		$display("cdp to standard_data_port_second test done");
		wb(1, 4'h0, 32'h1);
		att <= 1'b1;
		{n, sd, sp, bk, late} = '0;
		while (!bk && n < 3000) begin
			@(posedge clk_i);
			n++;
			if (dis === 1'b1 && !sp) sd = 1;
			if (sd && mode === 3'h4 && dsw === 1'b1) sp = 1;
			if (sp && dis !== 1'b0) late = 1;
			if (sp && mode === 3'h6) bk = 1;
		end
		chk(sd, 1);
		chk(sp, 1);
		chk({bk[0], late[0]}, 2'b10);
		$display("fallback test done");
		att <= 1'b0;
		settle(4'h6);
		for (int k = 0; k < 2; k++) begin
			if (k)
				wb(1, 4'h0, 32'h5);
			else
				ot <= 1'b1;
			repeat (30) @(posedge clk_i);
			chk(pwr, 0);
			if (k)
				wb(1, 4'h0, 32'h1);
			ot <= 1'b0;
			cool <= 1'b1;
			n = 0;
			while (pwr !== 1'b1 && n < 300) begin
				@(posedge clk_i);
				n++;
			end
			cool <= 1'b0;
			chk(pwr, 1);
		end
		$display("thermal test done");
		settle(4'hf);
		wb(1, 4'h0, 32'h3);
		repeat (300) @(posedge clk_i);
		chk(mode, 3'h4);
		wb(1, 4'h0, 32'h0);
		settle(4'h6);
		$display("software event test done");
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk({dis, mode}, 4'h8);
		rst_i <= 1'b0;
		settle(4'h6);
		$display("mid-run reset test done");
		end_of_test();
	end
endmodule // test_charge_port_mode_decoder
